// ### swi_pkg.sv
`default_nettype none
// =============================================================
// Shared constants for sleep, wake and interrupt timing
package swi_pkg;
    // Sleep mode select encodings
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    // Width of the phase counter
    localparam int CNT_W = 8;
    // Interrupt entry, sleep penalty, vector jump, return (cycles)
    localparam logic [7:0] ENTRY_CYC = 8'h04;
    localparam logic [7:0] SLEEP_EXTRA_CYC = 8'h04;
    localparam logic [7:0] JUMP_CYC = 8'h03;
    localparam logic [7:0] RETI_CYC = 8'h04;
    // Start-up delays after wake (plain defaults, cycles)
    localparam logic [7:0] IDLE_WAKE_CYC = 8'h01;
    localparam logic [7:0] FAST_WAKE_CYC = 8'h06;
    localparam logic [7:0] SLOW_WAKE_CYC = 8'h40;
    // Fuse bit that selects the slow start-up
    localparam int FUSE_SLOW_BIT = 3;
    // Reset value of the filtered pin levels (idle high)
    localparam logic [2:0] PIN_RESET_VAL = 3'h7;
    // Controller states, one-hot
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_SLEEP = 6'h02,
        ST_WAKE = 6'h04,
        ST_ENTRY = 6'h08,
        ST_JUMP = 6'h10,
        ST_RETURN = 6'h20
    } swi_state_t;
endpackage
`default_nettype wire

// ### swi_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Three-stage pin synchroniser with agreement filter
module swi_pin_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinLevel
);
    logic [W-1:0] s1_reg; // First stage, read only by s2
    logic [W-1:0] s2_reg; // Second stage
    logic [W-1:0] s3_reg; // Third stage

    // Shift chain
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_reg <= swi_pkg::PIN_RESET_VAL[W-1:0];
            s2_reg <= swi_pkg::PIN_RESET_VAL[W-1:0];
            s3_reg <= swi_pkg::PIN_RESET_VAL[W-1:0];
        end else if (ce) begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Level changes only where stages two and three agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinLevel <= swi_pkg::PIN_RESET_VAL[W-1:0];
        end else if (ce) begin
            pinLevel <= (s2_reg & ~(s2_reg ^ s3_reg))
                | (pinLevel & (s2_reg ^ s3_reg));
        end
    end
endmodule // swi_pin_sync
`default_nettype wire

// ### swi_cycle_timer.sv
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Loadable down-counter that times each controller phase
module swi_cycle_timer #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    output logic lastCycle
);
    logic [W-1:0] count_reg; // Cycles left in the phase

    // Load on phase entry, count down to zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (ce) begin
            if (load) begin
                count_reg <= loadValue;
            end else if (count_reg != '0) begin
                count_reg <= count_reg - W'(1);
            end
        end
    end

    // High in the final cycle of the phase
    assign lastCycle = (count_reg == W'(1));
endmodule // swi_cycle_timer
`default_nettype wire

// ### swi_sleep_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE1 - Instruction after interrupt enable runs first
// RULE2 - Interrupt entry lasts four cycles, pushing PC
// RULE3 - Vector jump occupies three cycles
// RULE4 - Multi-cycle instruction completes before entry
// RULE5 - Wake from sleep adds four entry cycles
// RULE6 - Return takes four cycles, pops, sets flag
// RULE7 - Mode 000 idle halts core, flash clocks
// RULE8 - Idle wakes on external or internal interrupts
// RULE9 - Idle or noise mode starts a conversion
// RULE10 - Mode 001 halts I/O, core, flash clocks
// RULE11 - Noise mode wakes on listed sources only
// RULE12 - Mode 010 power-down stops oscillator, clocks
// RULE13 - Power-down wakes on resets, match, level
// RULE14 - Level source holds until wake registers
// RULE15 - Power-down wake waits fuse-selected start-up
// RULE16 - Mode 011 power-save keeps async timer 2
// RULE17 - Timer 2 wakes only if masked and enabled
// RULE18 - Prefer power-down without async timer 2
// RULE19 - Comparator disable powers the comparator down
// =============================================================
// Sleep, wake and interrupt timing controller
module swi_sleep_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Core handshakes
    input wire logic sleepExec,
    input wire logic seiExec,
    input wire logic retiExec,
    input wire logic instrDone,
    input wire logic irqPending,
    input wire logic globalIrqFlag,
    // Configuration bits
    input wire logic [2:0] sleep_mode_select,
    input wire logic [3:0] clock_source_fuses,
    input wire logic comparator_disable,
    input wire logic timer2_async_select,
    input wire logic [1:0] timer_irq_mask,
    input wire logic adcEnable,
    // Wake sources
    input wire logic adcDone,
    input wire logic twiMatch,
    input wire logic timer2Irq,
    input wire logic timer2Overflow,
    input wire logic timer2Compare,
    input wire logic storeReady,
    input wire logic watchdogReset,
    input wire logic brownOutReset,
    // Pins, asynchronous, active low
    input wire logic ext_irq_zero_n,
    input wire logic ext_irq_one_n,
    input wire logic extReset_n,
    // Clock gates and power
    output logic cpuClkEn,
    output logic flashClkEn,
    output logic ioClkEn,
    output logic adcClkEn,
    output logic oscEn,
    output logic asyncTimerClkEn,
    output logic comparatorPowerEn,
    // Core sequencing
    output logic coreHold,
    output logic sleeping,
    output logic pcPush,
    output logic jumpActive,
    output logic pcPop,
    output logic irqAck,
    output logic vectorFetch,
    output logic spIncBy2,
    output logic setGlobalFlag,
    output logic adcStart
);
    // =========================================================
    // Declarations
    swi_pkg::swi_state_t state_reg; // Controller state
    swi_pkg::swi_state_t state_next; // Next state
    logic [2:0] mode_reg; // Mode latched at sleep entry
    logic seiShadow_reg; // One-instruction hold after enable
    logic irqWake_reg; // Wake caused by an interrupt
    logic extraEntry_reg; // Current entry follows sleep
    logic phaseLoad; // Reload the phase counter
    logic [7:0] phaseValue; // Value to load
    logic phaseLast; // Final cycle of the phase
    logic [2:0] pinLevel; // Filtered pin levels
    logic extLevel; // Either level interrupt asserted
    logic resetWake; // Any reset source
    logic irqWake; // Interrupt wake allowed in mode
    logic irqTake; // Take an interrupt now
    logic modeValid; // Sleep encoding is implemented
    logic inSleep; // Sleeping or starting up
    logic deepMode; // Power-down or power-save

    // Decoded states
    logic stRun;
    logic stSleep;
    logic stWake;
    logic stEntry;
    logic stJump;
    logic stReturn;
    assign stRun = (state_reg == swi_pkg::ST_RUN);
    assign stSleep = (state_reg == swi_pkg::ST_SLEEP);
    assign stWake = (state_reg == swi_pkg::ST_WAKE);
    assign stEntry = (state_reg == swi_pkg::ST_ENTRY);
    assign stJump = (state_reg == swi_pkg::ST_JUMP);
    assign stReturn = (state_reg == swi_pkg::ST_RETURN);

    // =========================================================
    // Functions
    // Interrupt sources allowed to wake in a given mode
    function automatic logic wakeFor(input logic [2:0] mode,
        input logic pend, input logic lvl, input logic adc,
        input logic twi, input logic t2, input logic st,
        input logic t2Gate);
        logic w;
        w = 1'b0;
        case (mode)
            swi_pkg::MODE_IDLE: w = pend | lvl; // [RULE8]
            swi_pkg::MODE_NOISE:
                w = adc | twi | t2 | st | lvl; // [RULE11]
            swi_pkg::MODE_PDOWN: w = twi | lvl; // [RULE13]
            swi_pkg::MODE_PSAVE: w = twi | lvl | t2Gate; // [RULE16]
            default: w = 1'b0;
        endcase
        return w;
    endfunction

    // Start-up delay for the sleep mode and fuses
    function automatic logic [7:0] wakeCycles(input logic [2:0] mode,
        input logic [3:0] fuses);
        logic [7:0] c;
        c = swi_pkg::IDLE_WAKE_CYC;
        if (mode == swi_pkg::MODE_PDOWN
            || mode == swi_pkg::MODE_PSAVE) begin
            // Oscillator restart time follows the fuses [RULE15]
            c = fuses[swi_pkg::FUSE_SLOW_BIT]
                ? swi_pkg::SLOW_WAKE_CYC : swi_pkg::FAST_WAKE_CYC;
        end
        return c;
    endfunction

    // =========================================================
    // Pin synchronisers and wake decode
    // Level sources must stay low until the filter agrees [RULE14]
    swi_pin_sync #(
        .W(3)
    ) pinSync (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .pinIn({extReset_n, ext_irq_one_n, ext_irq_zero_n}),
        .pinLevel(pinLevel)
    );

    assign extLevel = !pinLevel[0] || !pinLevel[1];
    assign resetWake = !pinLevel[2] || watchdogReset || brownOutReset;
    // Timer 2 wake needs async clock, mask and global flag [RULE17]
    assign irqWake = wakeFor(mode_reg, irqPending, extLevel, adcDone,
        twiMatch, timer2Irq, storeReady,
        timer2_async_select && globalIrqFlag
        && ((timer2Overflow && timer_irq_mask[0])
        || (timer2Compare && timer_irq_mask[1])));
    assign modeValid = (sleep_mode_select[2] == 1'b0);
    // Entry only at an instruction boundary, not in the hold [RULE4]
    assign irqTake = irqPending && globalIrqFlag && instrDone
        && !seiShadow_reg && !seiExec; // [RULE1]

    // =========================================================
    // Phase counter
    swi_cycle_timer #(
        .W(swi_pkg::CNT_W)
    ) phaseTimer (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .load(phaseLoad),
        .loadValue(phaseValue),
        .lastCycle(phaseLast)
    );

    // =========================================================
    // Next state and phase loads
    always_comb begin
        state_next = state_reg;
        phaseLoad = 1'b0;
        phaseValue = swi_pkg::ENTRY_CYC;
        case (state_reg)
            swi_pkg::ST_RUN: begin
                if (retiExec) begin
                    // Return sequence [RULE6]
                    state_next = swi_pkg::ST_RETURN;
                    phaseLoad = 1'b1;
                    phaseValue = swi_pkg::RETI_CYC;
                end else if (sleepExec && modeValid) begin
                    state_next = swi_pkg::ST_SLEEP;
                end else if (irqTake) begin
                    // Plain entry [RULE2]
                    state_next = swi_pkg::ST_ENTRY;
                    phaseLoad = 1'b1;
                end
            end
            swi_pkg::ST_SLEEP: begin
                if (resetWake || irqWake) begin
                    state_next = swi_pkg::ST_WAKE;
                    phaseLoad = 1'b1;
                    phaseValue = wakeCycles(mode_reg,
                        clock_source_fuses); // [RULE15]
                end
            end
            swi_pkg::ST_WAKE: begin
                if (phaseLast) begin
                    if (irqWake_reg && globalIrqFlag && irqPending) begin
                        // Sleep adds cycles after start-up [RULE5]
                        state_next = swi_pkg::ST_ENTRY;
                        phaseLoad = 1'b1;
                        phaseValue = 8'(swi_pkg::ENTRY_CYC
                            + swi_pkg::SLEEP_EXTRA_CYC);
                    end else begin
                        state_next = swi_pkg::ST_RUN;
                    end
                end
            end
            swi_pkg::ST_ENTRY: begin
                if (phaseLast) begin
                    // Vector holds a three-cycle jump [RULE3]
                    state_next = swi_pkg::ST_JUMP;
                    phaseLoad = 1'b1;
                    phaseValue = swi_pkg::JUMP_CYC;
                end
            end
            swi_pkg::ST_JUMP: begin
                if (phaseLast) begin
                    state_next = swi_pkg::ST_RUN;
                end
            end
            swi_pkg::ST_RETURN: begin
                if (phaseLast) begin
                    state_next = swi_pkg::ST_RUN;
                end
            end
            default: state_next = swi_pkg::ST_RUN;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= swi_pkg::ST_RUN;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Mode latch, wake cause and sleep-entry marker
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_reg <= swi_pkg::MODE_IDLE;
            irqWake_reg <= 1'b0;
            extraEntry_reg <= 1'b0;
        end else if (ce) begin
            if (stRun && sleepExec && modeValid) begin
                mode_reg <= sleep_mode_select;
            end
            if (stSleep) begin
                irqWake_reg <= !resetWake;
            end
            if (phaseLoad) begin
                extraEntry_reg <= stWake;
            end
        end
    end

    // Hold after interrupt enable; set wins over clear [RULE1]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            seiShadow_reg <= 1'b0;
        end else if (ce) begin
            if (seiExec) begin
                seiShadow_reg <= 1'b1;
            end else if (instrDone || sleepExec) begin
                seiShadow_reg <= 1'b0;
            end
        end
    end

    // =========================================================
    // Registered event pulses
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irqAck <= 1'b0;
            vectorFetch <= 1'b0;
            spIncBy2 <= 1'b0;
            setGlobalFlag <= 1'b0;
            adcStart <= 1'b0;
        end else if (ce) begin
            irqAck <= phaseLoad && state_next == swi_pkg::ST_ENTRY;
            vectorFetch <= stEntry && phaseLast; // [RULE2]
            spIncBy2 <= stReturn && phaseLast; // [RULE6]
            setGlobalFlag <= stReturn && phaseLast; // [RULE6]
            // Conversion on idle or noise entry [RULE9]
            adcStart <= stRun && sleepExec && adcEnable
                && (sleep_mode_select == swi_pkg::MODE_IDLE
                || sleep_mode_select == swi_pkg::MODE_NOISE);
        end
    end

    // =========================================================
    // Clock gating per sleep mode
    assign inSleep = stSleep || stWake;
    assign deepMode = (mode_reg == swi_pkg::MODE_PDOWN)
        || (mode_reg == swi_pkg::MODE_PSAVE);
    assign cpuClkEn = !inSleep; // [RULE7]
    assign flashClkEn = !inSleep; // [RULE7]
    assign ioClkEn = !(inSleep && mode_reg != swi_pkg::MODE_IDLE); // [RULE10]
    assign adcClkEn = !(inSleep && deepMode); // [RULE10]
    assign oscEn = !(stSleep && deepMode); // [RULE12]
    // Async timer runs in power-save when selected [RULE16]
    assign asyncTimerClkEn = !(inSleep && deepMode)
        || (mode_reg == swi_pkg::MODE_PSAVE && timer2_async_select);
    assign comparatorPowerEn = !comparator_disable; // [RULE19]
    assign coreHold = !stRun;
    assign sleeping = stSleep;
    assign pcPush = stEntry; // [RULE2]
    assign jumpActive = stJump; // [RULE3]
    assign pcPop = stReturn; // [RULE6]

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n || !ce);

    entry_len_a: assert property ($rose(pcPush) && !extraEntry_reg // [RULE2]
        |-> pcPush[*4] ##1 jumpActive)
        else $error("entry not four cycles");
    wake_entry_a: assert property ($rose(pcPush) && extraEntry_reg // [RULE5]
        |-> pcPush[*8] ##1 jumpActive)
        else $error("wake entry not eight cycles");
    jump_len_a: assert property ($rose(jumpActive) // [RULE3]
        |-> jumpActive[*3] ##1 (!jumpActive && !coreHold))
        else $error("jump not three cycles");
    return_len_a: assert property ($rose(pcPop) // [RULE6]
        |-> pcPop[*4] ##1 (!pcPop && spIncBy2 && setGlobalFlag))
        else $error("return sequence wrong");
    sei_hold_a: assert property ((seiExec || seiShadow_reg) && stRun // [RULE1]
        |=> !pcPush)
        else $error("entry right after enable");
    boundary_a: assert property ($rose(pcPush) // [RULE4]
        |-> $past(instrDone) || $past(stWake))
        else $error("entry mid instruction");
    idle_clk_a: assert property (stSleep // [RULE7]
        && mode_reg == swi_pkg::MODE_IDLE
        |-> !cpuClkEn && !flashClkEn && ioClkEn && adcClkEn)
        else $error("idle clock gating wrong");
    adc_start_a: assert property (stRun && sleepExec && adcEnable // [RULE9]
        && sleep_mode_select == swi_pkg::MODE_NOISE
        |=> adcStart && sleeping && !ioClkEn)
        else $error("no conversion on noise entry");
    pdown_clk_a: assert property (stSleep // [RULE12]
        && mode_reg == swi_pkg::MODE_PDOWN
        |-> !oscEn && !ioClkEn && !asyncTimerClkEn)
        else $error("power-down clocks running");
    psave_gate_a: assert property (stSleep // [RULE17]
        && mode_reg == swi_pkg::MODE_PSAVE && !globalIrqFlag
        && !resetWake && !twiMatch && !extLevel |=> sleeping)
        else $error("power-save woke ungated");

    entry_seen_c: cover property ($rose(pcPush) && !extraEntry_reg);
    wake_entry_c: cover property ($rose(pcPush) && extraEntry_reg);
    return_seen_c: cover property ($rose(pcPop));
    psave_wake_c: cover property (stSleep
        && mode_reg == swi_pkg::MODE_PSAVE ##1 stWake);
endmodule // swi_sleep_ctrl
`default_nettype wire

// ### swi_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Core pacing and pin source model for the far side
module swi_core_model (
    input wire logic clk,
    input wire logic run,
    input wire logic coreHold,
    input wire logic sleeping,
    input wire logic [1:0] pinReq,
    output logic instrDone = 1'b0,
    output logic [1:0] pinN
);
    logic [1:0] cntReg = 2'h0; // Cycle within a three-cycle instruction
    logic [1:0] holdReg = 2'h0; // Pins pulled low, one bit each
    // Three-cycle instructions, restarted from the first cycle while the core is held
    always_ff @(posedge clk) begin
        if (!run || coreHold) begin
            cntReg <= 2'h0;
            instrDone <= 1'b0;
        end else begin
            cntReg <= (cntReg == 2'h2) ? 2'h0 : cntReg + 2'h1;
            instrDone <= (cntReg == 2'h1);
        end
    end
    // A requested level stays low until the core has woken
    always_ff @(posedge clk) begin
        holdReg <= sleeping ? (holdReg | pinReq) : pinReq;
    end
    assign pinN = ~holdReg;
endmodule // swi_core_model
`default_nettype wire

// ### test_swi_sleep_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// =============================================================
// Self-checking bench for the sleep and interrupt timing controller
module test_swi_sleep_ctrl;
    // Mode, fuses, mask, blocked sources, waking source, sleep clocks,
    // conversion start, wake cycles (0 = unchecked), entry cycles
    typedef struct packed {
        logic [2:0] mode;
        logic [3:0] fuse;
        logic [1:0] mask;
        logic [8:0] blk;
        logic [8:0] wake;
        logic [5:0] clkEn;
        logic adcS;
        logic [7:0] wakeCyc;
        logic [7:0] push;
    } swi_row_t;
    swi_row_t rows [9]; // Sleep cases
    logic clk, reset_n, ce, sleepExec, seiExec, retiExec, tbDone;
    logic globalIrqFlag, comparator_disable, timer2_async_select;
    logic adcEnable, extReset_n, run, coreDone, instrDone, prevDone;
    logic [2:0] sleep_mode_select;
    logic [3:0] clock_source_fuses;
    logic [1:0] timer_irq_mask, pinReq, pinN;
    // Sources: pending, conv done, match, ovf, store, t2, wdog, bor, cmp
    logic [8:0] src;
    logic cpuClkEn, flashClkEn, ioClkEn, adcClkEn, oscEn, asyncTimerClkEn;
    logic comparatorPowerEn, coreHold, sleeping, pcPush, jumpActive;
    logic pcPop, irqAck, vectorFetch, spIncBy2, setGlobalFlag, adcStart;
    logic [5:0] clkVec; // All clock enables, core first
    int errors, tests_run, p, r;
    int cnt [8]; // push, jump, pop, ack, vector, sp, wake, spare
    assign instrDone = coreDone | tbDone;
    assign clkVec = {cpuClkEn, flashClkEn, ioClkEn, adcClkEn, oscEn,
                     asyncTimerClkEn};
    // Device under test
    swi_sleep_ctrl dut (
        .clk(clk), .reset_n(reset_n), .ce(ce), .sleepExec(sleepExec),
        .seiExec(seiExec), .retiExec(retiExec), .instrDone(instrDone),
        .irqPending(src[8]), .globalIrqFlag(globalIrqFlag),
        .sleep_mode_select(sleep_mode_select),
        .clock_source_fuses(clock_source_fuses),
        .comparator_disable(comparator_disable),
        .timer2_async_select(timer2_async_select),
        .timer_irq_mask(timer_irq_mask), .adcEnable(adcEnable),
        .adcDone(src[7]), .twiMatch(src[6]), .timer2Overflow(src[5]),
        .storeReady(src[4]), .timer2Irq(src[3]), .watchdogReset(src[2]),
        .brownOutReset(src[1]), .timer2Compare(src[0]),
        .ext_irq_zero_n(pinN[0]), .ext_irq_one_n(pinN[1]),
        .extReset_n(extReset_n), .cpuClkEn(cpuClkEn),
        .flashClkEn(flashClkEn), .ioClkEn(ioClkEn), .adcClkEn(adcClkEn),
        .oscEn(oscEn), .asyncTimerClkEn(asyncTimerClkEn),
        .comparatorPowerEn(comparatorPowerEn), .coreHold(coreHold),
        .sleeping(sleeping), .pcPush(pcPush), .jumpActive(jumpActive),
        .pcPop(pcPop), .irqAck(irqAck), .vectorFetch(vectorFetch),
        .spIncBy2(spIncBy2), .setGlobalFlag(setGlobalFlag),
        .adcStart(adcStart)
    );
    // Far-side core and pin model
    swi_core_model core (
        .clk(clk), .run(run), .coreHold(coreHold), .sleeping(sleeping),
        .pinReq(pinReq), .instrDone(coreDone), .pinN(pinN)
    );
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    // Counts, verdict, end of run
    task automatic print_verdict;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Count phase cycles from now until the core is released
    task automatic track(input int lim);
        int i;
        foreach (cnt[k]) cnt[k] = 0;
        for (i = 0; i < lim; i++) begin
            cnt[0] += int'(pcPush);
            cnt[1] += int'(jumpActive);
            cnt[2] += int'(pcPop);
            cnt[3] += int'(irqAck);
            cnt[4] += int'(vectorFetch);
            cnt[5] += int'(spIncBy2 & setGlobalFlag);
            cnt[6] += int'(coreHold & !sleeping & !pcPush & !jumpActive
                           & !pcPop);
            if (coreHold !== 1'b1) break;
            @(negedge clk);
        end
        if (i == lim) begin
            errors++;
            print_verdict;
        end
    endtask
    // Issue a sleep instruction
    task automatic do_sleep;
        sleepExec = 1'b1;
        cyc(1);
        sleepExec = 1'b0;
    endtask
    // Main sequence
    initial begin
        {ce, globalIrqFlag, timer2_async_select, adcEnable} = 4'hf;
        {reset_n, sleepExec, seiExec, retiExec, tbDone, run} = 6'h00;
        {comparator_disable, extReset_n} = 2'h1;
        {sleep_mode_select, clock_source_fuses} = 7'h00;
        {timer_irq_mask, pinReq, src} = 13'h0000;
        errors = 0;
        tests_run = 0;
        rows[0] = {3'h0, 4'h0, 2'h0, 9'h000, 9'h100, 6'h0f, 1'h1, 8'h01, 8'h08};
        rows[1] = {3'h1, 4'h0, 2'h0, 9'h100, 9'h080, 6'h07, 1'h1, 8'h01, 8'h00};
        rows[2] = {3'h1, 4'h0, 2'h0, 9'h020, 9'h010, 6'h07, 1'h1, 8'h01, 8'h00};
        rows[3] = {3'h1, 4'h0, 2'h0, 9'h000, 9'h008, 6'h07, 1'h1, 8'h01, 8'h00};
        rows[4] = {3'h2, 4'h0, 2'h0, 9'h080, 9'h040, 6'h00, 1'h0, 8'h06, 8'h00};
        rows[5] = {3'h2, 4'h8, 2'h0, 9'h010, 9'h004, 6'h00, 1'h0, 8'h00, 8'h00};
        // Power-save only with the timer on its own clock
        rows[6] = {3'h3, 4'h0, 2'h1, 9'h001, 9'h020, 6'h01, 1'h0, 8'h06, 8'h00};
        rows[7] = {3'h3, 4'h8, 2'h2, 9'h020, 9'h001, 6'h01, 1'h0, 8'h40, 8'h00};
        rows[8] = {3'h2, 4'h0, 2'h0, 9'h008, 9'h002, 6'h00, 1'h0, 8'h00, 8'h00};
        cyc(6);
        reset_n = 1'b1;
        check(clkVec, 6'h3f);
        check(coreHold, 1'b0);
        cyc(4);
        comparator_disable = 1'b1;
        cyc(1);
        check(comparatorPowerEn, 1'b0);
        comparator_disable = 1'b0;
        cyc(1);
        check(comparatorPowerEn, 1'b1);
        // Sleep table: clocks, blocked sources, wake and entry
        for (r = 0; r < 9; r++) begin
            sleep_mode_select = rows[r].mode;
            clock_source_fuses = rows[r].fuse;
            timer_irq_mask = rows[r].mask;
            do_sleep();
            check(sleeping, 1'b1);
            check(clkVec, rows[r].clkEn);
            check(adcStart, rows[r].adcS);
            src = rows[r].blk;
            cyc(6);
            check(sleeping, 1'b1);
            src = rows[r].wake;
            track(200);
            check(cnt[0], rows[r].push);
            if (rows[r].wakeCyc != 8'h00) begin
                check(cnt[6], rows[r].wakeCyc);
            end
            src = 9'h000;
            cyc(2);
        end
        // Plain entry between multi-cycle instructions
        run = 1'b1;
        src[8] = 1'b1;
        for (r = 0; r < 30 && coreHold !== 1'b1; r++) begin
            prevDone = instrDone;
            cyc(1);
        end
        if (coreHold !== 1'b1) begin
            errors++;
            print_verdict;
        end
        src[8] = 1'b0;
        check(prevDone, 1'b1);
        track(50);
        check(cnt[0], 4);
        check(cnt[1], 3);
        check(cnt[3] + cnt[4], 2);
        run = 1'b0;
        cyc(2);
        // Return from the handler
        retiExec = 1'b1;
        cyc(1);
        retiExec = 1'b0;
        track(20);
        check(cnt[2], 4);
        check(cnt[5], 1);
        // Enable then sleep with an interrupt already waiting
        sleep_mode_select = 3'h0;
        src[8] = 1'b1;
        seiExec = 1'b1;
        tbDone = 1'b1;
        cyc(1);
        seiExec = 1'b0;
        do_sleep();
        tbDone = 1'b0;
        check({sleeping, irqAck}, 2'h2);
        track(50);
        check(cnt[0], 8);
        src[8] = 1'b0;
        // Reserved mode codes leave the core running
        sleep_mode_select = 3'h4;
        do_sleep();
        check(coreHold, 1'b0);
        cyc(1);
        // Level pins wake power-down, external reset skips entry
        sleep_mode_select = 3'h2;
        for (p = 1; p < 4; p++) begin
            do_sleep();
            src[8] = 1'b1;
            cyc(6);
            check(sleeping, 1'b1);
            pinReq = (p < 3) ? p[1:0] : 2'h0;
            extReset_n = (p < 3);
            track(100);
            check(cnt[0], (p < 3) ? 8 : 0);
            {pinReq, src, extReset_n} = 12'h001;
            cyc(6);
        end
        // Power-save timer wake waits for the global flag
        sleep_mode_select = 3'h3;
        {globalIrqFlag, timer_irq_mask} = 3'h3;
        do_sleep();
        src = 9'h021;
        cyc(6);
        check(sleeping, 1'b1);
        {ce, src} = 10'h040;
        cyc(3);
        check(sleeping, 1'b1);
        ce = 1'b1;
        track(100);
        check(cnt[6], 6);
        {globalIrqFlag, src} = 10'h200;
        print_verdict;
    end
endmodule // test_swi_sleep_ctrl
`default_nettype wire
